// ---- rtl/gpio_ts_params.svh ----
`ifndef GPIO_TS_PARAMS_SVH
`define GPIO_TS_PARAMS_SVH
// printed offsets are not all multiples of four: kept as indexes
`define IDX_PIN_LEVEL 8'h52
`define IDX_DATA_EN 8'h53
`define IDX_CTRL_EN 8'h54
`define RST_PIN_LEVEL 8'h00
`define RST_DATA_EN 8'h00
`define RST_CTRL_EN 8'h00
`define BIT_FRAMING_EN 1
`define BIT_BYTE_CLK_EN 0
`define PIN_LEVEL_MASK 8'hfd
`define CTRL_EN_MASK 8'h03
`endif

// ---- rtl/gpio_ts_pkg.sv ----
package gpio_ts_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b010,
        ST_ACCESS = 3'b100
    } apb_state_t;
endpackage : gpio_ts_pkg

// ---- rtl/reg_access_if.sv ----
`timescale 1ns/1ps
interface reg_access_if;
    logic wr_strobe;
    logic [7:0] index;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit;
    modport bus (output wr_strobe, output index, output wdata, input rdata, input hit);
    modport regs (input wr_strobe, input index, input wdata, output rdata, output hit);
endinterface : reg_access_if

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    // first stage feeds only the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end
    assign sync_out = stage2_reg;
endmodule : pin_sync

// ---- rtl/apb_byte_slave.sv ----
`timescale 1ns/1ps
`include "gpio_ts_params.svh"
module apb_byte_slave (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    reg_access_if.bus ra
);
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    wire setup_phase = psel && !penable;
    wire aligned = (paddr[1:0] == 2'b00);
    // refused accesses neither write nor leak a register on read
    wire mapped = aligned && ra.hit && (paddr[11:10] == 2'b00);
    wire access_done = psel && penable && pready_reg;
    // no wait state: answer registered at the end of setup, valid in the first access cycle
    assign ra.index = paddr[9:2];
    assign ra.wdata = pwdata[7:0];
    assign ra.wr_strobe = access_done && pwrite && mapped && pstrb[0];
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup_phase;
            pslverr_reg <= setup_phase && !mapped;
            prdata_reg <= (setup_phase && !pwrite && mapped) ? {24'h000000, ra.rdata} :
                          32'h0000_0000;
        end
    end
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
endmodule : apb_byte_slave

// ---- rtl/gpio_ts_enables.sv ----
`timescale 1ns/1ps
`include "gpio_ts_params.svh"
module gpio_ts_enables (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] gpio_pins_in,
    input wire logic [7:0] stream_data_in,
    input wire logic packet_frame_strobe_in,
    input wire logic packet_first_byte_flag_in,
    input wire logic packet_error_flag_in,
    input wire logic stream_byte_clock_in,
    output logic [7:0] stream_data_out,
    output logic [7:0] stream_data_oe,
    output logic packet_frame_strobe_out,
    output logic packet_first_byte_flag_out,
    output logic packet_error_flag_out,
    output logic framing_oe,
    output logic byte_clock_out,
    output logic byte_clock_oe
);
    reg_access_if ra();
    gpio_ts_pkg::reg_byte_t pin_level_reg;
    gpio_ts_pkg::reg_byte_t stream_data_pin_enables_reg;
    gpio_ts_pkg::reg_byte_t stream_control_pin_enables_reg;
    logic [7:0] pins_sync;
    logic [7:0] data_out_reg;
    logic [2:0] framing_out_reg;
    logic byte_clock_out_reg;
    logic framing_oe_reg;
    logic byte_clock_oe_reg;
    logic [7:0] data_oe_reg;

    apb_byte_slave u_bus (
        .clock(clock),
        .sys_rst(sys_rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ra(ra.bus)
    );

    pin_sync #(.WIDTH(8)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(gpio_pins_in),
        .sync_out(pins_sync)
    );

    wire sel_level = (ra.index == `IDX_PIN_LEVEL);
    wire sel_data = (ra.index == `IDX_DATA_EN);
    wire sel_ctrl = (ra.index == `IDX_CTRL_EN);
    assign ra.hit = sel_level || sel_data || sel_ctrl;
    assign ra.rdata = sel_level ? pin_level_reg :
                      sel_data ? stream_data_pin_enables_reg :
                      sel_ctrl ? stream_control_pin_enables_reg : 8'h00;
    wire framing_en = stream_control_pin_enables_reg[`BIT_FRAMING_EN];
    wire clk_en = stream_control_pin_enables_reg[`BIT_BYTE_CLK_EN];

    // readback refreshed every cycle, three flops behind the pin
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_level_reg <= `RST_PIN_LEVEL;
        end else begin
            pin_level_reg <= pins_sync & `PIN_LEVEL_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stream_data_pin_enables_reg <= `RST_DATA_EN;
            stream_control_pin_enables_reg <= `RST_CTRL_EN;
        end else if (ra.wr_strobe) begin
            if (sel_data) begin
                stream_data_pin_enables_reg <= ra.wdata;
            end
            if (sel_ctrl) begin
                stream_control_pin_enables_reg <= ra.wdata & `CTRL_EN_MASK;
            end
        end
    end

    // pads get registered copies; costs one cycle of latency on the stream
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_data
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    data_oe_reg[gi] <= 1'b0;
                    data_out_reg[gi] <= 1'b0;
                end else begin
                    data_oe_reg[gi] <= stream_data_pin_enables_reg[gi];
                    data_out_reg[gi] <= stream_data_in[gi] & stream_data_pin_enables_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            framing_oe_reg <= 1'b0;
            byte_clock_oe_reg <= 1'b0;
            framing_out_reg <= 3'b000;
            byte_clock_out_reg <= 1'b0;
        end else begin
            framing_oe_reg <= framing_en;
            byte_clock_oe_reg <= clk_en;
            framing_out_reg <= {packet_frame_strobe_in, packet_first_byte_flag_in,
                                packet_error_flag_in} & {3{framing_en}};
            byte_clock_out_reg <= stream_byte_clock_in & clk_en;
        end
    end

    assign stream_data_out = data_out_reg;
    assign stream_data_oe = data_oe_reg;
    assign packet_frame_strobe_out = framing_out_reg[2];
    assign packet_first_byte_flag_out = framing_out_reg[1];
    assign packet_error_flag_out = framing_out_reg[0];
    assign framing_oe = framing_oe_reg;
    assign byte_clock_out = byte_clock_out_reg;
    assign byte_clock_oe = byte_clock_oe_reg;

    property p_bit1_zero;
        @(posedge clock) disable iff (sys_rst) pin_level_reg[1] == 1'b0;
    endproperty
    a_bit1_zero: assert property (p_bit1_zero) else $error("readback bit 1 not zero");

    // the readback check holds off until the sync chain has refilled after reset
    logic [1:0] settle_cnt_reg;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            settle_cnt_reg <= 2'h0;
        end else if (settle_cnt_reg != 2'h3) begin
            settle_cnt_reg <= settle_cnt_reg + 2'h1;
        end
    end

    property p_level_follows;
        @(posedge clock) disable iff (sys_rst)
            settle_cnt_reg == 2'h3 |->
                pin_level_reg == ($past(gpio_pins_in, 3) & `PIN_LEVEL_MASK);
    endproperty
    a_level_follows: assert property (p_level_follows) else $error("readback lags pins");

    property p_data_oe;
        @(posedge clock) disable iff (sys_rst)
            ##1 stream_data_oe == $past(stream_data_pin_enables_reg);
    endproperty
    a_data_oe: assert property (p_data_oe) else $error("data enable mismatch");

    property p_data_write;
        @(posedge clock) disable iff (sys_rst)
            ra.wr_strobe && sel_data |=> stream_data_pin_enables_reg == $past(ra.wdata);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data enable write lost");

    property p_reset_clear;
        @(posedge clock) sys_rst |=> stream_data_pin_enables_reg == 8'h00
            && stream_control_pin_enables_reg == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("enables not cleared");

    property p_framing_oe;
        @(posedge clock) disable iff (sys_rst)
            ##1 framing_oe == $past(stream_control_pin_enables_reg[1]);
    endproperty
    a_framing_oe: assert property (p_framing_oe) else $error("framing enable mismatch");

    property p_reset_oe;
        @(posedge clock) sys_rst |=> !framing_oe && !byte_clock_oe && stream_data_oe == 8'h00;
    endproperty
    a_reset_oe: assert property (p_reset_oe) else $error("outputs enabled after reset");

    property p_clk_gate;
        @(posedge clock) disable iff (sys_rst)
            !byte_clock_oe |-> !byte_clock_out;
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("byte clock toggles while off");

    property p_reserved;
        @(posedge clock) disable iff (sys_rst) stream_control_pin_enables_reg[7:2] == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved control bits set");

    property p_float;
        @(posedge clock) disable iff (sys_rst)
            !framing_oe |-> framing_out_reg == 3'b000;
    endproperty
    a_float: assert property (p_float) else $error("framing driven while off");

    property p_bclk_oe;
        @(posedge clock) disable iff (sys_rst)
            ##1 byte_clock_oe == $past(stream_control_pin_enables_reg[`BIT_BYTE_CLK_EN]);
    endproperty
    a_bclk_oe: assert property (p_bclk_oe) else $error("clock enable mismatch");

    property p_data_gate;
        @(posedge clock) disable iff (sys_rst)
            ##1 stream_data_out ==
                ($past(stream_data_in) & $past(stream_data_pin_enables_reg));
    endproperty
    a_data_gate: assert property (p_data_gate) else $error("data gate mismatch");

    property p_frame_out;
        @(posedge clock) disable iff (sys_rst)
            ##1 framing_out_reg == ($past({packet_frame_strobe_in, packet_first_byte_flag_in,
                packet_error_flag_in}) & {3{$past(framing_en)}});
    endproperty
    a_frame_out: assert property (p_frame_out) else $error("framing gate mismatch");

    property p_bclk_out;
        @(posedge clock) disable iff (sys_rst)
            ##1 byte_clock_out == ($past(stream_byte_clock_in) & $past(clk_en));
    endproperty
    a_bclk_out: assert property (p_bclk_out) else $error("byte clock gate mismatch");

    property p_ctrl_write;
        @(posedge clock) disable iff (sys_rst)
            ra.wr_strobe && sel_ctrl |=>
                stream_control_pin_enables_reg == ($past(ra.wdata) & `CTRL_EN_MASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");

    // enables move only on a decoded write; a stray strobe would open pads
    property p_data_hold;
        @(posedge clock) disable iff (sys_rst)
            !(ra.wr_strobe && sel_data) |=> $stable(stream_data_pin_enables_reg);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data enables changed");

    property p_ctrl_hold;
        @(posedge clock) disable iff (sys_rst)
            !(ra.wr_strobe && sel_ctrl) |=> $stable(stream_control_pin_enables_reg);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control enables changed");

    property p_no_bad_write;
        @(posedge clock) disable iff (sys_rst)
            ra.wr_strobe |-> paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0;
    endproperty
    a_no_bad_write: assert property (p_no_bad_write) else $error("refused write taken");

    property p_level_rdata;
        @(posedge clock) disable iff (sys_rst) sel_level |-> ra.rdata[1] == 1'b0;
    endproperty
    a_level_rdata: assert property (p_level_rdata) else $error("readback bit 1 set");

    property p_ctrl_rdata;
        @(posedge clock) disable iff (sys_rst) sel_ctrl |-> ra.rdata[7:2] == 6'h00;
    endproperty
    a_ctrl_rdata: assert property (p_ctrl_rdata) else $error("reserved bits read back");

    property p_data_rdata;
        @(posedge clock) disable iff (sys_rst) sel_data |-> ra.rdata == stream_data_pin_enables_reg;
    endproperty
    a_data_rdata: assert property (p_data_rdata) else $error("data enables read wrong");

    property p_level_reset;
        @(posedge clock) sys_rst |=> pin_level_reg == `RST_PIN_LEVEL;
    endproperty
    a_level_reset: assert property (p_level_reset) else $error("readback not cleared");

    property p_pad_reset;
        @(posedge clock) sys_rst |=> stream_data_out == 8'h00 && framing_out_reg == 3'h0
            && !byte_clock_out;
    endproperty
    a_pad_reset: assert property (p_pad_reset) else $error("pads driven after reset");

    property p_data_float;
        @(posedge clock) disable iff (sys_rst)
            (stream_data_out & ~stream_data_oe) == 8'h00;
    endproperty
    a_data_float: assert property (p_data_float) else $error("data driven while off");

    property p_bad_rdata;
        @(posedge clock) disable iff (sys_rst)
            psel && penable && pready && pslverr |-> prdata == 32'h0000_0000;
    endproperty
    a_bad_rdata: assert property (p_bad_rdata) else $error("refused read leaked data");

    c_data_wr: cover property (@(posedge clock) ra.wr_strobe && sel_data);
    c_ctrl_wr: cover property (@(posedge clock) ra.wr_strobe && sel_ctrl);
    c_level_rd: cover property (@(posedge clock) psel && penable && pready && !pwrite && sel_level);
    c_refused: cover property (@(posedge clock) psel && penable && pready && pslverr);
    c_all_open: cover property (@(posedge clock)
        framing_oe && byte_clock_oe && stream_data_oe == 8'hff);
endmodule : gpio_ts_enables

// ---- test/gpio_ts_enables_tb_top.sv ----
`timescale 1ns/1ps
module gpio_ts_enables_tb_top;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] gpio_pins_in = 8'h00;
    logic [7:0] stream_data_in = 8'h3c;
    logic frame_in = 1'b1;
    logic first_in = 1'b0;
    logic err_in = 1'b1;
    logic bclk_in = 1'b1;
    logic [7:0] stream_data_out;
    logic [7:0] stream_data_oe;
    logic frame_out, first_out, err_out, framing_oe, byte_clock_out, byte_clock_oe;
    int miscompares = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] v;
    logic [7:0] tbl [5] = '{8'h01, 8'h80, 8'ha5, 8'h5a, 8'hff};

    always #12.5 clock = ~clock;

    gpio_ts_enables dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpio_pins_in(gpio_pins_in),
        .stream_data_in(stream_data_in), .packet_frame_strobe_in(frame_in),
        .packet_first_byte_flag_in(first_in), .packet_error_flag_in(err_in),
        .stream_byte_clock_in(bclk_in), .stream_data_out(stream_data_out),
        .stream_data_oe(stream_data_oe), .packet_frame_strobe_out(frame_out),
        .packet_first_byte_flag_out(first_out), .packet_error_flag_out(err_out),
        .framing_oe(framing_oe), .byte_clock_out(byte_clock_out),
        .byte_clock_oe(byte_clock_oe));

    // waits for pready without assuming a latency; the watchdog ends a hang
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task rchk(input logic [11:0] a, input logic [7:0] exp, input logic ex_err);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h00_0000, exp}, "read data");
        chk({31'h0, er}, {31'h0, ex_err}, "error flag");
    endtask : rchk

    task results;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        chk({stream_data_oe, 6'h0, framing_oe, byte_clock_oe}, 16'h0000, "oe at reset");
        rchk(12'h148, 8'h00, 1'b0);
        rchk(12'h14c, 8'h00, 1'b0);
        rchk(12'h150, 8'h00, 1'b0);
        $display("reset values done");
        // level on the unused bit position must never leak into the readback
        foreach (tbl[i]) begin
            gpio_pins_in <= tbl[i] | 8'h02;
            repeat (4) @(posedge clock);
            rchk(12'h148, tbl[i] & 8'hfd, 1'b0);
        end
        apb(1'b1, 12'h148, 8'hff);
        chk({31'h0, er}, 32'h0, "read-only write error");
        rchk(12'h148, tbl[4] & 8'hfd, 1'b0);
        $display("pin readback done");
        foreach (tbl[i]) begin
            apb(1'b1, 12'h14c, tbl[i]);
            rchk(12'h14c, tbl[i], 1'b0);
            repeat (2) @(posedge clock);
            chk({24'h0, stream_data_oe}, {24'h0, tbl[i]}, "data oe");
            chk({24'h0, stream_data_out}, {24'h0, stream_data_in & tbl[i]}, "data out");
        end
        $display("data enables done");
        for (int k = 0; k < 4; k++) begin
            v = 8'hfc | k[7:0];
            apb(1'b1, 12'h150, v);
            rchk(12'h150, v & 8'h03, 1'b0);
            repeat (2) @(posedge clock);
            chk({31'h0, framing_oe}, {31'h0, v[1]}, "framing oe");
            chk({31'h0, byte_clock_oe}, {31'h0, v[0]}, "byte clock oe");
            if (v[1]) chk({29'h0, frame_out, first_out, err_out}, 32'h5, "framing out");
            else chk({29'h0, frame_out, first_out, err_out}, 32'h0, "framing off");
            if (v[0]) chk({31'h0, byte_clock_out}, 32'h1, "byte clock out");
            else chk({31'h0, byte_clock_out}, 32'h0, "byte clock off");
        end
        $display("control enables done");
        rchk(12'h154, 8'h00, 1'b1);
        rchk(12'h14e, 8'h00, 1'b1);
        apb(1'b1, 12'h154, 8'hff);
        chk({31'h0, er}, 32'h1, "unmapped write error");
        // upper address bits set: refused, and the data enables must keep their value
        apb(1'b1, 12'h54c, 8'h00);
        chk({31'h0, er}, 32'h1, "high address write error");
        rchk(12'h14c, 8'hff, 1'b0);
        rchk(12'h548, 8'h00, 1'b1);
        $display("refused accesses done");
        // a second reset in mid-run must clear every gate again
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        chk({stream_data_oe, 6'h0, framing_oe, byte_clock_oe}, 16'h0000, "oe after reset");
        rchk(12'h14c, 8'h00, 1'b0);
        rchk(12'h150, 8'h00, 1'b0);
        $display("second reset done");
        results();
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        $display("MISMATCH %0t watchdog expired", $time);
        results();
    end
endmodule : gpio_ts_enables_tb_top
